// *** dv/dpr_resp_tb.sv ***
`timescale 1ns/1ps
module dpr_resp_tb;
  import dpr_pkg::*;
  logic mclk = 0, rst_n = 0, pdcm_enable = 1, ss_en = 0;
  logic frame_sync = 0, slot_start = 0, pdcm_start = 0, kac_enable = 1;
  logic cmd_valid = 0, cmd_ok = 0, diag_fragment_size = 0;
  logic slow = 0, stall = 0, out_ready;
  logic [3:0] node_addr = 4'h3, source_identifier = 0, status_in = 0;
  logic [9:0] sensor_data = 0;
  logic [5:0] cmd_bits = 0;
  logic [7:0] cmd_reg_addr = 0, reg_read_addr;
  logic [15:0] diag_payload = 0;
  logic sample_req, crc_busy, reg_read_req, diag_pending, out_valid;
  logic [ENT_W-1:0] out_data;
  dpr_cmd_t cmd_kind = CMD_OTHER;
  logic [ENT_W-1:0] exp_q[$];
  logic [1:0] kac[16];
  int n_mismatch = 0, cmp_count = 0;
  logic rd_seen = 1'b0;

  dpr_resp dut (.mclk, .rst_n, .pdcm_enable, .ss_en, .frame_sync,
    .slot_start, .sample_req, .node_addr, .pdcm_start, .source_identifier,
    .kac_enable, .status_in, .sensor_data, .crc_busy, .cmd_valid, .cmd_kind,
    .cmd_bits, .cmd_ok, .cmd_reg_addr, .reg_read_req, .reg_read_addr,
    .diag_payload, .diag_fragment_size, .diag_pending, .out_valid,
    .out_ready, .out_data);
  dpr_sink sink (.mclk, .slow, .stall, .out_valid, .out_ready, .out_data);

  always #5 mclk = ~mclk;

  task complete_run;
    if (n_mismatch == 0 && cmp_count > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask : complete_run

  task chk(input logic [31:0] seen, input logic [31:0] want);
    cmp_count++;
    if (seen !== want) begin
      n_mismatch++;
      $display("BAD t=%0t seen=%h want=%h", $time, seen, want);
    end
  endtask : chk

  task tick;
    @(posedge mclk);
    #1;
  endtask : tick

  task wait_n(input int n);
    int i;
    for (i = 0; i < 900 && sink.got.size() < n; i++)
      tick;
    if (sink.got.size() < n) begin
      n_mismatch++;
      complete_run;
    end
  endtask : wait_n

  function automatic logic [7:0] ref_crc(input logic [19:0] m);
    logic [7:0]  r;
    logic [27:0] s;
    r = {4'h0, m[19:16]};
    s = {m, 8'h00};
    for (int i = 27; i >= 0; i--)
      r = {r[6:0], s[i]} ^ (r[7] ? 8'h2f : 8'h00);
    return r;
  endfunction : ref_crc

  task start_frame(input logic [3:0] sid, input logic [9:0] d);
    int i;
    logic [19:0] m;
    for (i = 0; i < 900 && crc_busy !== 1'b0; i++)
      tick;
    if (crc_busy !== 1'b0) begin
      n_mismatch++;
      complete_run;
    end
    m = {sid, kac_enable ? kac[sid] : 2'h0, status_in, d};
    exp_q.push_back({2'b00, m, ref_crc(m)});
    if (kac_enable)
      kac[sid] = kac[sid] + 2'h1;
    source_identifier = sid;
    sensor_data = d;
    pdcm_start = 1;
    tick;
    pdcm_start = 0;
    chk(crc_busy, 1);
  endtask : start_frame

  task drain;
    wait_n(exp_q.size());
    foreach (exp_q[k])
      chk(sink.got[k], exp_q[k]);
  endtask : drain

  task cmd(input dpr_cmd_t k, input logic [5:0] b, input logic ok);
    cmd_kind = k;
    cmd_bits = b;
    cmd_ok = ok;
    cmd_reg_addr = 8'h3c;
    cmd_valid = 1;
    tick;
    cmd_valid = 0;
    rd_seen = reg_read_req;
    tick;
  endtask : cmd

  task t_crc;
    logic [9:0] td[4] = '{10'h1ff, 10'h1fe, 10'h20d, 10'h1ea};
    logic [7:0] tc[4] = '{8'hd6, 8'h70, 8'hb0, 8'h5f};
    int last[4] = '{3, 6, 8, 9};
    sink.got.delete();
    exp_q.delete();
    slow = 1;
    for (int s = 1; s <= 4; s++)
      for (int j = 0; j <= 4 - s; j++)
        start_frame(s[3:0], td[s-1]);
    drain;
    for (int s = 0; s < 4; s++)
      chk(sink.got[last[s]][7:0], tc[s]);
    slow = 0;
  endtask : t_crc

  task t_stall;
    sink.got.delete();
    exp_q.delete();
    stall = 1;
    for (int j = 0; j < 2; j++)
      start_frame(4'h5, 10'h155 + j[9:0]);
    start_frame(4'h6, 10'h2aa);
    repeat (40) tick;
    chk(crc_busy, 1);
    stall = 0;
    drain;
  endtask : t_stall

  task t_diag(input logic sz, input logic [15:0] p);
    int n;
    sink.got.delete();
    n = sz ? 4 : 8;
    diag_fragment_size = sz;
    diag_payload = p;
    cmd(CMD_READ, 6'h20, 1'b1);
    chk(rd_seen, 1);
    chk(reg_read_addr, 8'h3c);
    chk(diag_pending, 1);
    for (int k = 0; k < n; k++) begin
      cmd(CMD_BRC, 6'h01, 1'b1);
      diag_payload = ~p;
    end
    wait_n(n);
    cmd(CMD_BRC, 6'h01, 1'b1);
    repeat (4) tick;
    chk(diag_pending, 0);
    chk(sink.got.size(), n);
    for (int k = 0; k < n; k++)
      chk(sink.got[k], sz ? {2'b11, 24'h0, p[15-4*k -: 4]}
                          : {2'b10, 26'h0, p[15-2*k -: 2]});
  endtask : t_diag

  task t_abort;
    for (int i = 0; i < 2; i++) begin
      sink.got.delete();
      cmd(CMD_READ, 6'h20, 1'b1);
      cmd(CMD_BRC, 6'h01, 1'b1);
      cmd(i ? CMD_OTHER : CMD_WRITE, 6'h20, 1'b1);
      chk(rd_seen, 0);
      chk(diag_pending, 0);
      cmd(CMD_BRC, 6'h01, 1'b1);
      repeat (4) tick;
      chk(sink.got.size(), 1);
    end
    cmd(CMD_READ, 6'h1f, 1'b1);
    chk(diag_pending, 0);
    cmd(CMD_READ, 6'h20, 1'b0);
    chk(rd_seen, 0);
  endtask : t_abort

  task t_samp;
    for (int s = 0; s < 3; s++) begin
      ss_en = s[0];
      pdcm_enable = (s < 2);
      frame_sync = 1;
      tick;
      frame_sync = 0;
      chk(sample_req, s == 1);
      slot_start = 1;
      tick;
      slot_start = 0;
      chk(sample_req, s == 0);
    end
    pdcm_enable = 1;
  endtask : t_samp

  task t_node0;
    sink.got.delete();
    exp_q.delete();
    node_addr = 4'h0;
    pdcm_start = 1;
    tick;
    pdcm_start = 0;
    chk(crc_busy, 0);
    repeat (35) tick;
    chk(sink.got.size(), 0);
    node_addr = 4'hf;
    status_in = 4'ha;
    kac_enable = 0;
    start_frame(4'h4, 10'h0f0);
    kac_enable = 1;
    start_frame(4'h4, 10'h30f);
    drain;
  endtask : t_node0

  initial begin
    foreach (kac[k])
      kac[k] = 2'h0;
    #1;
    repeat (3) tick;
    rst_n = 1;
    chk(out_valid, 0);
    chk(diag_pending, 0);
    t_crc;
    t_stall;
    t_diag(1'b1, 16'hbe2f);
    t_diag(1'b0, 16'h9c63);
    t_abort;
    t_samp;
    t_node0;
    complete_run;
  end
endmodule : dpr_resp_tb

// *** dv/dpr_sink.sv ***
`timescale 1ns/1ps
module dpr_sink
  import dpr_pkg::*;
(
  input  wire logic                      mclk,
  input  wire logic                      slow,
  input  wire logic                      stall,
  input  wire logic                      out_valid,
  output logic                           out_ready,
  input  wire logic [dpr_pkg::ENT_W-1:0] out_data
);
  import dpr_pkg::*;
  // Bus master side: takes frames and fragments, optionally slowly
  logic [ENT_W-1:0] got[$];
  logic [1:0]       ph_ff = 2'h0;
  always @(posedge mclk) begin
    ph_ff <= ph_ff + 2'h1;
    if (out_valid && out_ready)
      got.push_back(out_data);
  end
  assign out_ready = !stall && (!slow || ph_ff == 2'h3);
endmodule : dpr_sink

// *** hw/dpr_buf.sv ***
`timescale 1ns/1ps
module dpr_buf #(
  parameter int W     = 30,
  parameter int DEPTH = 2
) (
  input  wire logic         mclk,
  input  wire logic         rst_n,
  input  wire logic         in_valid,
  output logic              in_ready,
  input  wire logic [W-1:0] in_data,
  output logic              out_valid,
  input  wire logic         out_ready,
  output logic      [W-1:0] out_data
);
  localparam int PW = (DEPTH > 1) ? $clog2(DEPTH) : 1;
  localparam logic [PW:0]   FULL_CNT = (PW+1)'(DEPTH);
  localparam logic [PW-1:0] LAST_PTR = PW'(DEPTH - 1);

  logic [W-1:0]  mem_ff [DEPTH];
  logic [PW-1:0] wr_ff;
  logic [PW-1:0] rd_ff;
  logic [PW:0]   cnt_ff;
  logic          push;
  logic          pop;

  assign in_ready  = cnt_ff != FULL_CNT;
  assign out_valid = cnt_ff != '0;
  assign out_data  = mem_ff[rd_ff];
  assign push      = in_valid && in_ready;
  assign pop       = out_valid && out_ready;

  always_ff @(posedge mclk) begin
    if (push) begin
      mem_ff[wr_ff] <= in_data;
    end
  end

  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      wr_ff  <= '0;
      rd_ff  <= '0;
      cnt_ff <= '0;
    end else begin
      if (push) begin
        wr_ff <= (wr_ff == LAST_PTR) ? '0 : wr_ff + 1'b1;
      end
      if (pop) begin
        rd_ff <= (rd_ff == LAST_PTR) ? '0 : rd_ff + 1'b1;
      end
      if (push && !pop) begin
        cnt_ff <= cnt_ff + 1'b1;
      end else if (pop && !push) begin
        cnt_ff <= cnt_ff - 1'b1;
      end
    end
  end
endmodule : dpr_buf

// *** hw/dpr_pkg.sv ***
package dpr_pkg;
  localparam int         SID_W      = 4;
  localparam int         KAC_W      = 2;
  localparam int         STS_W      = 4;
  localparam int         DAT_W      = 10;
  localparam int         MSG_W      = 20;
  localparam int         CRC_W      = 8;
  localparam int         FRAME_W    = MSG_W + CRC_W;
  localparam int         ENT_W      = FRAME_W + 2;
  localparam int         DIAG_W     = 16;
  localparam int         FRAG_W     = 4;
  localparam int         CMD_CNT_W  = 6;
  localparam int         RADDR_W    = 8;
  localparam logic [7:0] CRC_POLY   = 8'h2f;
  localparam logic [3:0] SEED_HI    = 4'h0;
  localparam logic [4:0] SHIFT_LAST = 5'h1b;
  localparam logic [5:0] CMD_FULL   = 6'h20;
  localparam logic [3:0] FRAGS_TWO  = 4'h4;
  localparam logic [3:0] FRAGS_ONE  = 4'h8;
  localparam logic [3:0] NODE_MSTR  = 4'h0;
  localparam logic [1:0] KAC_INIT   = 2'h0;
  localparam int         SH_TWO     = 4;
  localparam int         SH_ONE     = 2;

  typedef enum logic [1:0] {
    CMD_BRC   = 2'h0,
    CMD_READ  = 2'h1,
    CMD_WRITE = 2'h2,
    CMD_OTHER = 2'h3
  } dpr_cmd_t;

  typedef enum logic [2:0] {
    CS_IDLE  = 3'h1,
    CS_SHIFT = 3'h2,
    CS_PUSH  = 3'h4
  } dpr_crc_st_t;

  typedef enum logic [2:0] {
    DS_IDLE  = 3'h1,
    DS_ARMED = 3'h2,
    DS_RUN   = 3'h4
  } dpr_dg_st_t;

  function automatic logic [7:0] crc_step(input logic [7:0] r,
                                          input logic       b);
    crc_step = {r[6:0], b} ^ (r[7] ? CRC_POLY : 8'h00);
  endfunction : crc_step
endpackage : dpr_pkg

// *** hw/dpr_resp.sv ***
`timescale 1ns/1ps
module dpr_resp
  import dpr_pkg::*;
(
  input  wire logic                      mclk,
  input  wire logic                      rst_n,
  input  wire logic                      pdcm_enable,
  input  wire logic                      ss_en,
  input  wire logic                      frame_sync,
  input  wire logic                      slot_start,
  output logic                           sample_req,
  input  wire logic [SID_W-1:0]          node_addr,
  input  wire logic                      pdcm_start,
  input  wire logic [SID_W-1:0]          source_identifier,
  input  wire logic                      kac_enable,
  input  wire logic [STS_W-1:0]          status_in,
  input  wire logic [DAT_W-1:0]          sensor_data,
  output logic                           crc_busy,
  input  wire logic                      cmd_valid,
  input  wire dpr_pkg::dpr_cmd_t         cmd_kind,
  input  wire logic [CMD_CNT_W-1:0]      cmd_bits,
  input  wire logic                      cmd_ok,
  input  wire logic [RADDR_W-1:0]        cmd_reg_addr,
  output logic                           reg_read_req,
  output logic      [RADDR_W-1:0]        reg_read_addr,
  input  wire logic [DIAG_W-1:0]         diag_payload,
  input  wire logic                      diag_fragment_size,
  output logic                           diag_pending,
  output logic                           out_valid,
  input  wire logic                      out_ready,
  output logic      [ENT_W-1:0]          out_data
);
  import dpr_pkg::*;

  dpr_crc_st_t       crc_st_ff;
  dpr_dg_st_t        dg_st_ff;
  logic [CRC_W-1:0]  crc_ff;
  logic [FRAME_W-1:0] sh_ff;
  logic [MSG_W-1:0]  msg_ff;
  logic [4:0]        cnt_ff;
  logic [KAC_W-1:0]  kac_ff [16];
  logic [KAC_W-1:0]  kac_now;
  logic [DIAG_W-1:0] hold_ff;
  logic [FRAG_W-1:0] frag_ff;
  logic              size_ff;
  logic              frag_pend_ff;
  logic [3:0]        frag_cnt_ff;
  logic [3:0]        frag_last;
  logic              node_ok;
  logic              start_go;
  logic              brc_go;
  logic              read_go;
  logic              kill_go;
  logic              dg_active;
  logic              buf_in_valid;
  logic              buf_in_ready;
  logic [ENT_W-1:0]  buf_in_data;
  logic [DIAG_W-1:0] src_word;
  logic [MSG_W-1:0]  nxt_msg;

  assign node_ok   = node_addr != NODE_MSTR;
  assign start_go  = pdcm_start && pdcm_enable && node_ok
                     && crc_st_ff == CS_IDLE;
  assign kac_now   = kac_enable ? kac_ff[source_identifier] : KAC_INIT;
  assign nxt_msg   = {source_identifier, kac_now, status_in,
                      sensor_data};
  assign dg_active = dg_st_ff != DS_IDLE;
  assign brc_go    = cmd_valid && cmd_kind == CMD_BRC && dg_active;
  assign read_go   = cmd_valid && pdcm_enable && node_ok
                     && cmd_kind == CMD_READ && cmd_bits == CMD_FULL
                     && cmd_ok;
  assign kill_go   = cmd_valid && cmd_kind != CMD_BRC && !read_go;
  assign frag_last = size_ff ? FRAGS_TWO : FRAGS_ONE;
  assign src_word  = (dg_st_ff == DS_ARMED) ? diag_payload : hold_ff;
  assign crc_busy  = crc_st_ff != CS_IDLE;
  assign diag_pending = dg_active;

  // Sampling strobe selection
  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      sample_req <= 1'b0;
    end else begin
      sample_req <= pdcm_enable && (ss_en ? frame_sync : slot_start);
    end
  end

  // Keep-alive counters per identifier
  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      for (int i = 0; i < 16; i++) begin
        kac_ff[i] <= KAC_INIT;
      end
    end else if (start_go && kac_enable) begin
      kac_ff[source_identifier] <= kac_now + 1'b1;
    end
  end

  // Serial checksum engine
  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      crc_st_ff <= CS_IDLE;
      crc_ff    <= '0;
      sh_ff     <= '0;
      msg_ff    <= '0;
      cnt_ff    <= '0;
    end else begin
      unique case (crc_st_ff)
        CS_IDLE: begin
          if (start_go) begin
            msg_ff    <= nxt_msg;
            sh_ff     <= {nxt_msg, {CRC_W{1'b0}}};
            crc_ff    <= {SEED_HI, source_identifier};
            cnt_ff    <= '0;
            crc_st_ff <= CS_SHIFT;
          end
        end
        CS_SHIFT: begin
          crc_ff <= crc_step(crc_ff, sh_ff[FRAME_W-1]);
          sh_ff  <= {sh_ff[FRAME_W-2:0], 1'b0};
          cnt_ff <= cnt_ff + 1'b1;
          if (cnt_ff == SHIFT_LAST) begin
            crc_st_ff <= CS_PUSH;
          end
        end
        CS_PUSH: begin
          if (buf_in_ready) begin
            crc_st_ff <= CS_IDLE;
          end
        end
      endcase
    end
  end

  // Background diagnostic sequencing
  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      dg_st_ff    <= DS_IDLE;
      frag_cnt_ff <= '0;
      size_ff     <= 1'b0;
    end else begin
      unique case (dg_st_ff)
        DS_IDLE: begin
          if (read_go) begin
            dg_st_ff    <= DS_ARMED;
            frag_cnt_ff <= '0;
            size_ff     <= diag_fragment_size;
          end
        end
        DS_ARMED, DS_RUN: begin
          if (read_go) begin
            dg_st_ff    <= DS_ARMED;
            frag_cnt_ff <= '0;
            size_ff     <= diag_fragment_size;
          end else if (kill_go) begin
            dg_st_ff <= DS_IDLE;
          end else if (brc_go) begin
            frag_cnt_ff <= frag_cnt_ff + 1'b1;
            dg_st_ff    <= (frag_cnt_ff + 1'b1 == frag_last) ? DS_IDLE
                                                             : DS_RUN;
          end
        end
      endcase
    end
  end

  // Payload holding and fragment slicing
  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      hold_ff <= '0;
      frag_ff <= '0;
    end else if (brc_go && !kill_go && !read_go) begin
      if (size_ff) begin
        frag_ff <= src_word[DIAG_W-1 -: FRAG_W];
        hold_ff <= src_word << SH_TWO;
      end else begin
        frag_ff <= {2'b00, src_word[DIAG_W-1 -: SH_ONE]};
        hold_ff <= src_word << SH_ONE;
      end
    end
  end

  // Fragment owed to the output
  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      frag_pend_ff <= 1'b0;
    end else if (brc_go && !kill_go && !read_go) begin
      frag_pend_ff <= 1'b1;
    end else if (buf_in_ready && crc_st_ff != CS_PUSH) begin
      frag_pend_ff <= 1'b0;
    end
  end

  // Register read request to the companion block
  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      reg_read_req  <= 1'b0;
      reg_read_addr <= '0;
    end else begin
      reg_read_req <= read_go;
      if (read_go) begin
        reg_read_addr <= cmd_reg_addr;
      end
    end
  end

  // Periodic frame has priority into the buffer
  assign buf_in_valid = crc_st_ff == CS_PUSH || frag_pend_ff;
  assign buf_in_data  = (crc_st_ff == CS_PUSH)
                        ? {1'b0, 1'b0, msg_ff, crc_ff}
                        : {1'b1, size_ff, {(FRAME_W-FRAG_W){1'b0}},
                           frag_ff};

  dpr_buf #(
    .W     (ENT_W),
    .DEPTH (2)
  ) u_buf (
    .mclk      (mclk),
    .rst_n     (rst_n),
    .in_valid  (buf_in_valid),
    .in_ready  (buf_in_ready),
    .in_data   (buf_in_data),
    .out_valid (out_valid),
    .out_ready (out_ready),
    .out_data  (out_data)
  );

  default clocking cb @(posedge mclk);
  endclocking
  default disable iff (!rst_n);

  seed_load_a: assert property (
    start_go |=> crc_ff == {SEED_HI, $past(source_identifier)})
    else $error("seed not loaded from identifier");

  msb_first_a: assert property (
    start_go |=> sh_ff[FRAME_W-1] == $past(source_identifier[SID_W-1]))
    else $error("message not fed msb first");

  augment_len_a: assert property (
    start_go |-> ##29 crc_st_ff == CS_PUSH)
    else $error("checksum length wrong");

  crc_append_a: assert property (
    crc_st_ff == CS_PUSH |-> buf_in_data[CRC_W-1:0] == crc_ff
                             && buf_in_data[ENT_W-1] == 1'b0)
    else $error("checksum not appended");

  arm_full_a: assert property (
    dg_st_ff == DS_IDLE && cmd_valid && cmd_bits != CMD_FULL
    |=> dg_st_ff == DS_IDLE)
    else $error("armed on short command");

  no_spont_a: assert property (
    frag_pend_ff && !$past(frag_pend_ff) |-> $past(brc_go))
    else $error("fragment without broadcast read");

  abandon_rest_a: assert property (
    dg_active && kill_go |=> dg_st_ff == DS_IDLE && !$rose(frag_pend_ff))
    else $error("answer not abandoned");

  frag_size_a: assert property (
    crc_st_ff != CS_PUSH && frag_pend_ff && !size_ff
    |-> buf_in_data[FRAG_W-1:SH_ONE] == 2'b00)
    else $error("fragment wider than size");

  hold_frozen_a: assert property (
    dg_st_ff == DS_RUN && !brc_go |=> $stable(hold_ff))
    else $error("held payload changed");

  write_none_a: assert property (
    cmd_valid && cmd_kind == CMD_WRITE |=> !reg_read_req)
    else $error("write command executed");

  sample_sel_a: assert property (
    pdcm_enable && ss_en && frame_sync |=> sample_req)
    else $error("simultaneous sample missed");

  node_mstr_a: assert property (
    node_addr == NODE_MSTR |-> !start_go && !read_go)
    else $error("master address answered");
endmodule : dpr_resp
